// ### core/gpio_dir_pkg.sv
package gpio_dir_pkg;

  // ==================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_PIN_DIRECTION_BANKS_0_1 = 8'h10;
  localparam logic [7:0] OFS_OUT01 = 8'h14;
  localparam logic [7:0] OFS_SET01 = 8'h18;
  localparam logic [7:0] OFS_CLR01 = 8'h1c;
  localparam logic [7:0] OFS_IN01  = 8'h20;
  localparam logic [7:0] OFS_PIN_DIRECTION_BANK_2  = 8'h38;
  localparam logic [7:0] OFS_OUT2  = 8'h3c;
  localparam logic [7:0] OFS_SET2  = 8'h40;
  localparam logic [7:0] OFS_CLR2  = 8'h44;
  localparam logic [7:0] OFS_IN2   = 8'h48;

  // ==================================================
  // Populated bit masks and reset values
  localparam logic [31:0] POP01      = 32'h07ff_3dff;
  localparam logic [31:0] POP2       = 32'h0000_07f3;
  localparam logic [31:0] DIR_RESET  = 32'hffff_ffff;
  localparam logic [31:0] OUT_RESET  = 32'h0000_0000;
  localparam logic [31:0] SYNC_RESET = 32'h0000_0000;

  // ==================================================
  // Bus carriers
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef struct packed {
    logic [31:0] pin_direction_banks_0_1;
    logic [31:0] pin_direction_bank_2;
    logic [31:0] out01;
    logic [31:0] out2;
    logic [31:0] meta01;
    logic [31:0] meta2;
    logic [31:0] sync01;
    logic [31:0] sync2;
    logic [31:0] rdata;
    logic [31:0] pin_o01;
    logic [31:0] pin_oe_n01;
    logic [31:0] pin_o2;
    logic [31:0] pin_oe_n2;
  } gpio_state_t;

endpackage

// ### core/gpio_pin_data_direction.sv
// Functional notes
// [RULE1] Direction bit 0 makes the pin output, 1 makes it input.
// [RULE2] Reset sets every direction bit to 1: all pins inputs.
// [RULE3] Each bank holds at most 16 pins, one bit each per field.
// [RULE4] Banks 0/1 share a register: bank 1 upper, bank 0 lower half.
// [RULE5] Output level bit drives the pin only while direction is output.
// [RULE6] Output bit 0 drives low, 1 drives high.
// [RULE7] Output level register reads back the stored value, not pins.
// [RULE8] Writing 1 to force-high sets output state; 0 leaves it.
// [RULE9] Writing 1 to force-low clears output state; 0 leaves it.
// [RULE10] Force-high and force-low registers read the output state.
// [RULE11] Output writes never change a pin configured as input.
// [RULE12] Input pins read back after synchronisation to the clock.
// [RULE13] Output pins read back the value being driven.
// [RULE14] Only populated bits writable; others read 1 in direction, 0 in data.
// [RULE15] Output, force-high and force-low share one state per pin.
// [RULE16] Input synchroniser uses two flip-flop stages.
//
// Design decisions made here: the address-and-strobe port and the address map.
module gpio_pin_data_direction (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // Pins, banks 0 and 1
  input  wire logic [31:0] pin_i01,
  output logic      [31:0] pin_o01,
  output logic      [31:0] pin_oe_n01,
  // Pins, bank 2
  input  wire logic [31:0] pin_i2,
  output logic      [31:0] pin_o2,
  output logic      [31:0] pin_oe_n2
);

  gpio_dir_pkg::gpio_state_t st_r;
  gpio_dir_pkg::gpio_state_t st_nxt;

  // ==================================================
  // Write of a mixed register keeps unpopulated bits fixed
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] pop);
    merge = (old & ~pop) | (nw & pop);                                // [RULE3] [RULE14]
  endfunction

  // Pin readback: driven value for outputs, synced level for inputs
  function automatic logic [31:0] level(input logic [31:0] dir, input logic [31:0] outv,
                                        input logic [31:0] syn, input logic [31:0] pop);
    level = ((outv & ~dir) | (syn & dir)) & pop;
  endfunction

  // ==================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    // Two-stage synchroniser
    st_nxt.meta01 = pin_i01;                                          // [RULE16]
    st_nxt.meta2  = pin_i2;                                           // [RULE16]
    st_nxt.sync01 = st_r.meta01;                                      // [RULE16] [RULE12]
    st_nxt.sync2  = st_r.meta2;                                       // [RULE16] [RULE12]
    if (wr) begin
      case (addr)
        gpio_dir_pkg::OFS_PIN_DIRECTION_BANKS_0_1: st_nxt.pin_direction_banks_0_1 = merge(st_r.pin_direction_banks_0_1, wdata, gpio_dir_pkg::POP01); // [RULE14] [RULE4]
        gpio_dir_pkg::OFS_PIN_DIRECTION_BANK_2:  st_nxt.pin_direction_bank_2  = merge(st_r.pin_direction_bank_2, wdata, gpio_dir_pkg::POP2);   // [RULE14] [RULE4]
        gpio_dir_pkg::OFS_OUT01: st_nxt.out01 = wdata & gpio_dir_pkg::POP01;                   // [RULE15]
        gpio_dir_pkg::OFS_OUT2:  st_nxt.out2  = wdata & gpio_dir_pkg::POP2;                    // [RULE15]
        gpio_dir_pkg::OFS_SET01: st_nxt.out01 = st_r.out01 | (wdata & gpio_dir_pkg::POP01);    // [RULE8]
        gpio_dir_pkg::OFS_SET2:  st_nxt.out2  = st_r.out2 | (wdata & gpio_dir_pkg::POP2);      // [RULE8]
        gpio_dir_pkg::OFS_CLR01: st_nxt.out01 = st_r.out01 & ~(wdata & gpio_dir_pkg::POP01);   // [RULE9]
        gpio_dir_pkg::OFS_CLR2:  st_nxt.out2  = st_r.out2 & ~(wdata & gpio_dir_pkg::POP2);     // [RULE9]
        default: ;
      endcase
    end
    // Read data, valid the cycle after the strobe only
    st_nxt.rdata = 32'h0000_0000;
    if (rd) begin
      case (addr)
        gpio_dir_pkg::OFS_PIN_DIRECTION_BANKS_0_1: st_nxt.rdata = st_r.pin_direction_banks_0_1;
        gpio_dir_pkg::OFS_PIN_DIRECTION_BANK_2:  st_nxt.rdata = st_r.pin_direction_bank_2;
        gpio_dir_pkg::OFS_OUT01,
        gpio_dir_pkg::OFS_SET01,
        gpio_dir_pkg::OFS_CLR01: st_nxt.rdata = st_r.out01;                                    // [RULE7] [RULE10]
        gpio_dir_pkg::OFS_OUT2,
        gpio_dir_pkg::OFS_SET2,
        gpio_dir_pkg::OFS_CLR2:  st_nxt.rdata = st_r.out2;                                     // [RULE7] [RULE10]
        gpio_dir_pkg::OFS_IN01:  st_nxt.rdata = level(st_r.pin_direction_banks_0_1, st_r.out01, st_r.sync01,
                                                      gpio_dir_pkg::POP01);                    // [RULE12] [RULE13]
        gpio_dir_pkg::OFS_IN2:   st_nxt.rdata = level(st_r.pin_direction_bank_2, st_r.out2, st_r.sync2,
                                                      gpio_dir_pkg::POP2);                     // [RULE12] [RULE13]
        default:                 st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    // Pin drive from next state; enable low means driving
    st_nxt.pin_oe_n01 = st_nxt.pin_direction_banks_0_1;                                 // [RULE1] [RULE11]
    st_nxt.pin_oe_n2  = st_nxt.pin_direction_bank_2;                                  // [RULE1] [RULE11]
    st_nxt.pin_o01    = st_nxt.out01 & ~st_nxt.pin_direction_banks_0_1;                 // [RULE5] [RULE6]
    st_nxt.pin_o2     = st_nxt.out2 & ~st_nxt.pin_direction_bank_2;                   // [RULE5] [RULE6]
  end

  // ==================================================
  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r.pin_direction_banks_0_1      <= gpio_dir_pkg::DIR_RESET;                     // [RULE2]
      st_r.pin_direction_bank_2       <= gpio_dir_pkg::DIR_RESET;                     // [RULE2]
      st_r.out01      <= gpio_dir_pkg::OUT_RESET;
      st_r.out2       <= gpio_dir_pkg::OUT_RESET;
      st_r.meta01     <= gpio_dir_pkg::SYNC_RESET;
      st_r.meta2      <= gpio_dir_pkg::SYNC_RESET;
      st_r.sync01     <= gpio_dir_pkg::SYNC_RESET;
      st_r.sync2      <= gpio_dir_pkg::SYNC_RESET;
      st_r.rdata      <= 32'h0000_0000;
      st_r.pin_o01    <= gpio_dir_pkg::OUT_RESET;
      st_r.pin_o2     <= gpio_dir_pkg::OUT_RESET;
      st_r.pin_oe_n01 <= gpio_dir_pkg::DIR_RESET;
      st_r.pin_oe_n2  <= gpio_dir_pkg::DIR_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata      = st_r.rdata;
  assign pin_o01    = st_r.pin_o01;
  assign pin_oe_n01 = st_r.pin_oe_n01;
  assign pin_o2     = st_r.pin_o2;
  assign pin_oe_n2  = st_r.pin_oe_n2;

  // ==================================================
  // Checks: direction and reset
  chk_dir_reset_inputs: assert property ( // [RULE2]
    @(posedge clock)
    $rose(!rst)
    |-> st_r.pin_direction_banks_0_1 == gpio_dir_pkg::DIR_RESET)
    else $error("direction not all inputs after reset");

  chk_pin_direction_bank_2_reset: assert property ( // [RULE2]
    @(posedge clock)
    $rose(!rst)
    |-> st_r.pin_direction_bank_2 == gpio_dir_pkg::DIR_RESET)
    else $error("bank 2 direction not all inputs after reset");

  chk_reset_oe_high: assert property ( // [RULE2]
    @(posedge clock)
    $rose(!rst)
    |-> (pin_oe_n01 == gpio_dir_pkg::DIR_RESET) && (pin_oe_n2 == gpio_dir_pkg::DIR_RESET))
    else $error("pin driven right after reset");

  chk_dir_enables: assert property ( // [RULE1]
    @(posedge clock) disable iff (rst)
    1'b1
    |-> pin_oe_n01 == st_r.pin_direction_banks_0_1)
    else $error("enable does not follow direction");

  chk_pin_direction_bank_2_enables: assert property ( // [RULE1]
    @(posedge clock) disable iff (rst)
    1'b1
    |-> pin_oe_n2 == st_r.pin_direction_bank_2)
    else $error("bank 2 enable does not follow direction");

  chk_pin_direction_banks_0_1_write: assert property ( // [RULE4]
    @(posedge clock) disable iff (rst)
    (wr && addr == gpio_dir_pkg::OFS_PIN_DIRECTION_BANKS_0_1)
    |=> st_r.pin_direction_banks_0_1 == (($past(wdata) & gpio_dir_pkg::POP01) | ~gpio_dir_pkg::POP01))
    else $error("direction write wrong");

  chk_pin_direction_bank_2_write: assert property ( // [RULE4]
    @(posedge clock) disable iff (rst)
    (wr && addr == gpio_dir_pkg::OFS_PIN_DIRECTION_BANK_2)
    |=> st_r.pin_direction_bank_2 == (($past(wdata) & gpio_dir_pkg::POP2) | ~gpio_dir_pkg::POP2))
    else $error("bank 2 direction write wrong");

  chk_dir_hold: assert property ( // [RULE1]
    @(posedge clock) disable iff (rst)
    !(wr && addr == gpio_dir_pkg::OFS_PIN_DIRECTION_BANKS_0_1)
    |=> $stable(st_r.pin_direction_banks_0_1))
    else $error("direction changed without write");

  chk_unpop_dir_fixed: assert property ( // [RULE14]
    @(posedge clock) disable iff (rst)
    ((st_r.pin_direction_banks_0_1 | gpio_dir_pkg::POP01) == 32'hffff_ffff)
    && ((st_r.pin_direction_bank_2 | gpio_dir_pkg::POP2) == 32'hffff_ffff))
    else $error("unpopulated direction bit cleared");

  chk_unpop_out_zero: assert property ( // [RULE14]
    @(posedge clock) disable iff (rst)
    ((st_r.out01 & ~gpio_dir_pkg::POP01) == 32'h0)
    && ((st_r.out2 & ~gpio_dir_pkg::POP2) == 32'h0))
    else $error("unpopulated output bit set");

  chk_bank2_upper_in: assert property ( // [RULE4]
    @(posedge clock) disable iff (rst)
    (st_r.pin_direction_bank_2[31:16] == 16'hffff)
    && (st_r.out2[31:16] == 16'h0000))
    else $error("bank 2 upper half in use");

  chk_bank_width: assert property ( // [RULE3]
    @(posedge clock) disable iff (rst)
    (pin_o2[31:16] == 16'h0000)
    && (pin_oe_n2[31:16] == 16'hffff))
    else $error("bank 2 drives beyond sixteen pins");

  // ==================================================
  // Checks: output state
  chk_input_not_driven: assert property ( // [RULE5]
    @(posedge clock) disable iff (rst)
    ((pin_oe_n01 & pin_o01) == 32'h0)
    && ((pin_oe_n2 & pin_o2) == 32'h0))
    else $error("input pin shows drive value");

  chk_pin_follows_out: assert property ( // [RULE6]
    @(posedge clock) disable iff (rst)
    1'b1
    |-> pin_o01 == (st_r.out01 & ~st_r.pin_direction_banks_0_1))
    else $error("pin level differs from output state");

  chk_pin2_follows_out: assert property ( // [RULE6]
    @(posedge clock) disable iff (rst)
    1'b1
    |-> pin_o2 == (st_r.out2 & ~st_r.pin_direction_bank_2))
    else $error("bank 2 pin level differs from output state");

  chk_out_write: assert property ( // [RULE15]
    @(posedge clock) disable iff (rst)
    (wr && addr == gpio_dir_pkg::OFS_OUT01)
    |=> st_r.out01 == ($past(wdata) & gpio_dir_pkg::POP01))
    else $error("output write wrong");

  chk_out2_write: assert property ( // [RULE15]
    @(posedge clock) disable iff (rst)
    (wr && addr == gpio_dir_pkg::OFS_OUT2)
    |=> st_r.out2 == ($past(wdata) & gpio_dir_pkg::POP2))
    else $error("bank 2 output write wrong");

  chk_set_high: assert property ( // [RULE8]
    @(posedge clock) disable iff (rst)
    (wr && addr == gpio_dir_pkg::OFS_SET01)
    |=> (st_r.out01 & $past(wdata) & gpio_dir_pkg::POP01) == ($past(wdata) & gpio_dir_pkg::POP01))
    else $error("force high not applied");

  chk_set2_high: assert property ( // [RULE8]
    @(posedge clock) disable iff (rst)
    (wr && addr == gpio_dir_pkg::OFS_SET2)
    |=> (st_r.out2 & $past(wdata) & gpio_dir_pkg::POP2) == ($past(wdata) & gpio_dir_pkg::POP2))
    else $error("bank 2 force high not applied");

  chk_set_keeps: assert property ( // [RULE8]
    @(posedge clock) disable iff (rst)
    (wr && addr == gpio_dir_pkg::OFS_SET2)
    |=> (st_r.out2 & ~$past(wdata)) == ($past(st_r.out2) & ~$past(wdata)))
    else $error("force high disturbed other bits");

  chk_set01_keeps: assert property ( // [RULE8]
    @(posedge clock) disable iff (rst)
    (wr && addr == gpio_dir_pkg::OFS_SET01)
    |=> (st_r.out01 & ~$past(wdata)) == ($past(st_r.out01) & ~$past(wdata)))
    else $error("bank 0/1 force high disturbed other bits");

  chk_clr_low: assert property ( // [RULE9]
    @(posedge clock) disable iff (rst)
    (wr && addr == gpio_dir_pkg::OFS_CLR01)
    |=> (st_r.out01 & $past(wdata)) == 32'h0)
    else $error("force low not applied");

  chk_clr2_low: assert property ( // [RULE9]
    @(posedge clock) disable iff (rst)
    (wr && addr == gpio_dir_pkg::OFS_CLR2)
    |=> (st_r.out2 & $past(wdata)) == 32'h0)
    else $error("bank 2 force low not applied");

  chk_clr_keeps: assert property ( // [RULE9]
    @(posedge clock) disable iff (rst)
    (wr && addr == gpio_dir_pkg::OFS_CLR01)
    |=> (st_r.out01 & ~$past(wdata)) == ($past(st_r.out01) & ~$past(wdata)))
    else $error("force low disturbed other bits");

  chk_clr2_keeps: assert property ( // [RULE9]
    @(posedge clock) disable iff (rst)
    (wr && addr == gpio_dir_pkg::OFS_CLR2)
    |=> (st_r.out2 & ~$past(wdata)) == ($past(st_r.out2) & ~$past(wdata)))
    else $error("bank 2 force low disturbed other bits");

  chk_out_hold: assert property ( // [RULE15]
    @(posedge clock) disable iff (rst)
    !(wr && (addr == gpio_dir_pkg::OFS_OUT01 || addr == gpio_dir_pkg::OFS_SET01 || addr == gpio_dir_pkg::OFS_CLR01))
    |=> $stable(st_r.out01))
    else $error("output state changed without write");

  chk_out2_hold: assert property ( // [RULE15]
    @(posedge clock) disable iff (rst)
    !(wr && (addr == gpio_dir_pkg::OFS_OUT2 || addr == gpio_dir_pkg::OFS_SET2 || addr == gpio_dir_pkg::OFS_CLR2))
    |=> $stable(st_r.out2))
    else $error("bank 2 output state changed without write");

  chk_input_pin_kept: assert property ( // [RULE11]
    @(posedge clock) disable iff (rst)
    (wr && addr == gpio_dir_pkg::OFS_SET01)
    |=> ((pin_o01 ^ $past(pin_o01)) & st_r.pin_direction_banks_0_1) == 32'h0)
    else $error("force high moved an input pin");

  chk_input_pin2_kept: assert property ( // [RULE11]
    @(posedge clock) disable iff (rst)
    (wr && addr == gpio_dir_pkg::OFS_CLR2)
    |=> ((pin_o2 ^ $past(pin_o2)) & st_r.pin_direction_bank_2) == 32'h0)
    else $error("force low moved an input pin");

  // ==================================================
  // Checks: read back
  chk_out_readback: assert property ( // [RULE10]
    @(posedge clock) disable iff (rst)
    (rd && addr == gpio_dir_pkg::OFS_CLR01 && !wr)
    |=> rdata == $past(st_r.out01))
    else $error("force low readback wrong");

  chk_set2_readback: assert property ( // [RULE10]
    @(posedge clock) disable iff (rst)
    (rd && addr == gpio_dir_pkg::OFS_SET2)
    |=> rdata == $past(st_r.out2))
    else $error("bank 2 force high readback wrong");

  chk_out01_readback: assert property ( // [RULE7]
    @(posedge clock) disable iff (rst)
    (rd && addr == gpio_dir_pkg::OFS_OUT01)
    |=> rdata == $past(st_r.out01))
    else $error("output readback wrong");

  chk_out2_readback: assert property ( // [RULE7]
    @(posedge clock) disable iff (rst)
    (rd && addr == gpio_dir_pkg::OFS_OUT2)
    |=> rdata == $past(st_r.out2))
    else $error("bank 2 output readback wrong");

  chk_dir_readback: assert property ( // [RULE1]
    @(posedge clock) disable iff (rst)
    (rd && addr == gpio_dir_pkg::OFS_PIN_DIRECTION_BANKS_0_1)
    |=> rdata == $past(st_r.pin_direction_banks_0_1))
    else $error("direction readback wrong");

  chk_pin_direction_bank_2_readback: assert property ( // [RULE1]
    @(posedge clock) disable iff (rst)
    (rd && addr == gpio_dir_pkg::OFS_PIN_DIRECTION_BANK_2)
    |=> rdata == $past(st_r.pin_direction_bank_2))
    else $error("bank 2 direction readback wrong");

  chk_in_readback: assert property ( // [RULE13]
    @(posedge clock) disable iff (rst)
    (rd && addr == gpio_dir_pkg::OFS_IN01)
    |=> rdata == ((($past(st_r.out01) & ~$past(st_r.pin_direction_banks_0_1)) | ($past(st_r.sync01) & $past(st_r.pin_direction_banks_0_1))) & gpio_dir_pkg::POP01))
    else $error("pin level readback wrong");

  chk_in2_readback: assert property ( // [RULE12]
    @(posedge clock) disable iff (rst)
    (rd && addr == gpio_dir_pkg::OFS_IN2)
    |=> rdata == ((($past(st_r.out2) & ~$past(st_r.pin_direction_bank_2)) | ($past(st_r.sync2) & $past(st_r.pin_direction_bank_2))) & gpio_dir_pkg::POP2))
    else $error("bank 2 pin level readback wrong");

  chk_in_unpop_zero: assert property ( // [RULE14]
    @(posedge clock) disable iff (rst)
    (rd && addr == gpio_dir_pkg::OFS_IN01)
    |=> (rdata & ~gpio_dir_pkg::POP01) == 32'h0)
    else $error("unpopulated pin level bit set");

  chk_rdata_idle: assert property ( // [RULE7]
    @(posedge clock) disable iff (rst)
    !rd
    |=> rdata == 32'h0)
    else $error("read data outside its cycle");

  // ==================================================
  // Checks: synchroniser
  chk_sync_two_stage: assert property ( // [RULE16]
    @(posedge clock) disable iff (rst)
    (!$past(rst) && !$past(rst, 2))
    |-> st_r.sync01 == $past(pin_i01, 2))
    else $error("synchroniser depth wrong");

  chk_sync2_two_stage: assert property ( // [RULE16]
    @(posedge clock) disable iff (rst)
    (!$past(rst) && !$past(rst, 2))
    |-> st_r.sync2 == $past(pin_i2, 2))
    else $error("bank 2 synchroniser depth wrong");

  chk_meta_first: assert property ( // [RULE16]
    @(posedge clock) disable iff (rst)
    !$past(rst)
    |-> st_r.meta01 == $past(pin_i01))
    else $error("first synchroniser stage wrong");

endmodule // gpio_pin_data_direction

// ### tb/gpio_pin_data_direction_tb_top.sv
module gpio_pin_data_direction_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rst, wr, rd;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, board01, board2, st;
  logic [31:0] pin_i01, pin_o01, pin_oe_n01, pin_i2, pin_o2, pin_oe_n2;
  int          errors, check_count;

  // ==================================================
  // Design and pin models
  gpio_pin_data_direction i_dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pin_i01(pin_i01), .pin_o01(pin_o01), .pin_oe_n01(pin_oe_n01), .pin_i2(pin_i2),
    .pin_o2(pin_o2), .pin_oe_n2(pin_oe_n2));
  gpio_pin_model i_pins01 (.pin_o(pin_o01), .pin_oe_n(pin_oe_n01), .board(board01), .pin_i(pin_i01));
  gpio_pin_model i_pins2 (.pin_o(pin_o2), .pin_oe_n(pin_oe_n2), .board(board2), .pin_i(pin_i2));

  // ==================================================
  // Access tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ==================================================
  // Clock, watchdog and tests
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    #100us;
    errors++;
    conclude();
  end
  initial begin
    {rst, wr, rd, addr, wdata} = {1'b1, 1'b0, 1'b0, 8'h00, 32'h0000_0000};
    board01 = 32'h5555_aaaa;
    board2  = 32'h0000_ffff;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rd_chk(gpio_dir_pkg::OFS_PIN_DIRECTION_BANKS_0_1, gpio_dir_pkg::DIR_RESET);
    rd_chk(gpio_dir_pkg::OFS_PIN_DIRECTION_BANK_2, gpio_dir_pkg::DIR_RESET);
    chk(pin_oe_n01, 32'hffff_ffff);
    wr_reg(gpio_dir_pkg::OFS_OUT01, 32'hffff_ffff);
    rd_chk(gpio_dir_pkg::OFS_OUT01, gpio_dir_pkg::POP01);
    chk(pin_o01 & ~pin_oe_n01, 32'h0000_0000);
    rd_chk(gpio_dir_pkg::OFS_IN01, 32'h5555_aaaa & gpio_dir_pkg::POP01);
    wr_reg(gpio_dir_pkg::OFS_PIN_DIRECTION_BANKS_0_1, 32'h0000_ffff);
    rd_chk(gpio_dir_pkg::OFS_PIN_DIRECTION_BANKS_0_1, 32'h0000_ffff | ~gpio_dir_pkg::POP01);
    chk(pin_oe_n01, 32'h0000_ffff | ~gpio_dir_pkg::POP01);
    chk(pin_o01, gpio_dir_pkg::POP01 & 32'hffff_0000);
    wr_reg(gpio_dir_pkg::OFS_CLR01, 32'h00f0_00f0);
    st = gpio_dir_pkg::POP01 & ~32'h00f0_00f0;
    rd_chk(gpio_dir_pkg::OFS_SET01, st);
    rd_chk(gpio_dir_pkg::OFS_CLR01, st);
    chk(pin_o01, st & 32'hffff_0000);
    rd_chk(gpio_dir_pkg::OFS_IN01, ((32'h5555_aaaa & 32'h0000_ffff) | (st & 32'hffff_0000)) & gpio_dir_pkg::POP01);
    wr_reg(gpio_dir_pkg::OFS_SET01, 32'h0010_0000);
    rd_chk(gpio_dir_pkg::OFS_OUT01, st | 32'h0010_0000);
    wr_reg(gpio_dir_pkg::OFS_PIN_DIRECTION_BANK_2, 32'h0000_0000);
    wr_reg(gpio_dir_pkg::OFS_OUT2, 32'hffff_a5a5);
    @(posedge clock);
    #1 chk(pin_o2, 32'h0000_a5a5 & gpio_dir_pkg::POP2);
    chk(pin_oe_n2, ~gpio_dir_pkg::POP2);
    rd_chk(gpio_dir_pkg::OFS_IN2, 32'h0000_a5a5 & gpio_dir_pkg::POP2);
    rd_chk(8'h04, 32'h0000_0000);
    conclude();
  end
endmodule // gpio_pin_data_direction_tb_top

// ### tb/gpio_pin_model.sv
module gpio_pin_model (
  // Device side
  input  wire logic [31:0] pin_o,
  input  wire logic [31:0] pin_oe_n,
  // Board side
  input  wire logic [31:0] board,
  output logic      [31:0] pin_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==================================================
  // Pin level: device drive where enabled, board level elsewhere
  always_comb pin_i = (pin_o & ~pin_oe_n) | (board & pin_oe_n);
endmodule // gpio_pin_model
